// *** shared/sfp_pkg.sv ***
// Shared types and constants for the serial flash pin interface
package sfp_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned LANES = 4;
    localparam int unsigned INSTR_BITS = 8;
    localparam int unsigned SYNC_W = 6;

    // ==========================================================
    // Pin carriers
    // ==========================================================
    typedef struct packed {
        logic cs_n;          // Chip select, active low
        logic sck;           // Serial clock from the host
        logic [3:0] dl;      // data_line_three .. data_line_zero
    } sfp_pin_in_t;

    typedef struct packed {
        logic [3:0] dl_out;  // Driven levels per data line
        logic [3:0] dl_oe;   // High while this end drives the line
    } sfp_pin_out_t;

    typedef struct packed {
        logic valid;         // One-cycle byte strobe
        logic instr;         // Byte is the instruction byte
        logic [7:0] data;    // Received byte
    } sfp_rx_t;

    // Idle pin levels: deselected, clock low, write-protect/hold high
    localparam logic [5:0] PIN_RST = 6'h2C;

    // ==========================================================
    // Line positions
    // ==========================================================
    localparam int unsigned LINE_ZERO = 0;
    localparam int unsigned LINE_ONE = 1;
    localparam int unsigned LINE_TWO = 2;
    localparam int unsigned LINE_THREE = 3;

    // ==========================================================
    // Transfer widths, one-hot
    // ==========================================================
    typedef enum logic [4:0] {
        MODE_SINGLE   = 5'h01,
        MODE_DUAL_OUT = 5'h02,
        MODE_QUAD_OUT = 5'h04,
        MODE_DUAL_IO  = 5'h08,
        MODE_QUAD_IO  = 5'h10
    } sfp_mode_t;

    localparam logic [3:0] MASK_SINGLE = 4'h2;
    localparam logic [3:0] MASK_DUAL = 4'h3;
    localparam logic [3:0] MASK_QUAD = 4'hF;

    // ==========================================================
    // Status lock pattern that arms hardware protection
    // ==========================================================
    localparam logic LOCK_HI_PROT = 1'h0;
    localparam logic LOCK_LO_PROT = 1'h1;

    // Reset values of control state
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;

endpackage

// *** design/sfp_sync.sv ***
// Two-stage synchroniser for the interface pins
`timescale 1ns/10ps
module sfp_sync (
    input wire logic clock_i,                  // System clock
    input wire logic reset_i,                  // Async reset, active high
    input wire logic [5:0] async_i,            // Raw pin levels
    output logic [5:0] sync_o                  // Synchronised levels
);

    logic [5:0] meta_ff;
    logic [5:0] hold_ff;

    // ==========================================================
    // One flop pair per pin
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < sfp_pkg::SYNC_W; gi++) begin : g_bit
            always_ff @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    meta_ff[gi] <= sfp_pkg::PIN_RST[gi];
                    hold_ff[gi] <= sfp_pkg::PIN_RST[gi];
                end else begin
                    meta_ff[gi] <= async_i[gi];
                    hold_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    assign sync_o = hold_ff;

endmodule // sfp_sync

// *** design/sfp_pin_if.sv ***
// Device-side pin interface of a serial flash: shifting, hold, protect
//
// Functional notes
// - Single mode: in on line zero, out line one.
// - Wide output: single in, out two/four lines.
// - Wide I/O: in and out same width.
// - Sample inputs on serial clock rising edge.
// - Change outputs only after clock falling edge.
// - Select high: ignore inputs, outputs released.
// - Standby when deselected and idle, else active.
// - No command before first select falling edge.
// - Protect pin low plus lock: refuse status writes.
// - Same condition: protected region not modifiable.
// - Quad enable turns protect pin into line two.
// - Hold pauses transfer, keeps state, stays selected.
// - Hold starts when hold low and clock low.
// - Hold ends when hold high and clock low.
// - During hold: outputs released, clock/input ignored.
// - Hold never aborts running internal operations.
// - Hash-named signals are active low.
// - Quad I/O: hold pin is line three.
// - Line zero carries group LSB, MSB group first.
`timescale 1ns/10ps
module sfp_pin_if (
    input wire logic clock_i,                       // 50 MHz system clock
    input wire logic reset_i,                       // Async reset, high
    input wire sfp_pkg::sfp_pin_in_t pins_i,        // Raw host pins
    output sfp_pkg::sfp_pin_out_t pins_o,           // Line drive/enable
    input wire sfp_pkg::sfp_mode_t mode_i,          // Current width mode
    input wire logic tx_en_i,                       // Output phase active
    input wire logic [7:0] tx_byte_i,               // Next byte to send
    output logic tx_take_o,                         // tx_byte_i consumed
    output sfp_pkg::sfp_rx_t rx_o,                  // Received byte
    input wire logic status_lock_bit_hi_i,          // Lock bit, reg two
    input wire logic status_lock_bit_lo_i,          // Lock bit, reg one
    input wire logic quad_enable_bit_i,             // Quad enable bit
    input wire logic region_hit_i,                  // Target in prot area
    input wire logic busy_i,                        // Embedded op running
    output logic status_write_allow_o,              // Status write allowed
    output logic array_write_allow_o,               // Array write allowed
    output logic standby_o,                         // Standby power state
    output logic selected_o,                        // Device selected
    output logic hold_o,                            // Hold condition on
    output logic cmd_end_o,                         // Select rose, pulse
    output logic byte_aligned_o                     // End was on boundary
);

    // ==========================================================
    // Width decoding
    // ==========================================================
    function automatic logic [3:0] rx_width(sfp_pkg::sfp_mode_t m,
                                            logic instr_done);
        if (!instr_done) begin
            return 4'h1;
        end
        unique case (m)
            sfp_pkg::MODE_DUAL_IO: return 4'h2;
            sfp_pkg::MODE_QUAD_IO: return 4'h4;
            default: return 4'h1;
        endcase
    endfunction

    function automatic logic [3:0] tx_width(sfp_pkg::sfp_mode_t m);
        unique case (m)
            sfp_pkg::MODE_DUAL_OUT, sfp_pkg::MODE_DUAL_IO: return 4'h2;
            sfp_pkg::MODE_QUAD_OUT, sfp_pkg::MODE_QUAD_IO: return 4'h4;
            default: return 4'h1;
        endcase
    endfunction

    function automatic logic [3:0] lane_mask(sfp_pkg::sfp_mode_t m);
        unique case (tx_width(m))
            4'h2: return sfp_pkg::MASK_DUAL;
            4'h4: return sfp_pkg::MASK_QUAD;
            default: return sfp_pkg::MASK_SINGLE;
        endcase
    endfunction

    // Top group of a byte placed on its lines, LSB on line zero; single mode puts its bit on line one
    function automatic logic [3:0] top_group(sfp_pkg::sfp_mode_t m,
                                             logic [7:0] b);
        unique case (tx_width(m))
            4'h2: return {2'b00, b[7:6]};
            4'h4: return b[7:4];
            default: return {2'b00, b[7], 1'b0};
        endcase
    endfunction

    function automatic logic [7:0] shift_by(logic [7:0] b,
                                            logic [3:0] w,
                                            logic [3:0] g);
        unique case (w)
            4'h2: return {b[5:0], g[1:0]};
            4'h4: return {b[3:0], g};
            default: return {b[6:0], g[0]};
        endcase
    endfunction

    // ==========================================================
    // Pin synchronisation and edge detection
    // ==========================================================
    sfp_pkg::sfp_pin_in_t pin_s;
    logic [5:0] pin_s_raw;

    sfp_sync u_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .async_i(pins_i),
        .sync_o(pin_s_raw)
    );
    assign pin_s = pin_s_raw;

    logic sck_q_ff;
    logic cs_q_ff;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sck_q_ff <= 1'b0;
            cs_q_ff <= 1'b1;
        end else begin
            sck_q_ff <= pin_s.sck;
            cs_q_ff <= pin_s.cs_n;
        end
    end

    assign sck_rise = pin_s.sck & ~sck_q_ff;
    assign sck_fall = ~pin_s.sck & sck_q_ff;
    assign cs_fall = ~pin_s.cs_n & cs_q_ff;
    assign cs_rise = pin_s.cs_n & ~cs_q_ff;

    // ==========================================================
    // Power-up arming and selection
    // ==========================================================
    logic armed_ff;
    logic sel;
    logic [2:0] settle_ff;

    // Synchroniser reset levels are not pin samples; wait them out
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            settle_ff <= sfp_pkg::CNT_RST[2:0];
        end else begin
            settle_ff <= {settle_ff[1:0], 1'b1};
        end
    end

    // Select held low across reset release does not count as a start
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            armed_ff <= 1'b0;
        end else if (cs_fall && settle_ff[2]) begin
            armed_ff <= 1'b1;
        end
    end

    assign sel = armed_ff & ~pin_s.cs_n;

    // ==========================================================
    // Hold condition
    // ==========================================================
    logic hold_ff;
    logic hold_func;
    logic act;
    logic rise_ok;
    logic fall_ok;

    // Quad operation owns line three, so the pause function is off
    assign hold_func = ~(quad_enable_bit_i &
                         (mode_i == sfp_pkg::MODE_QUAD_IO ||
                          mode_i == sfp_pkg::MODE_QUAD_OUT));

    // Waiting for clock low covers both the coincident and late cases
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            hold_ff <= 1'b0;
        end else if (!sel || !hold_func) begin
            hold_ff <= 1'b0;
        end else if (!hold_ff && !pin_s.dl[sfp_pkg::LINE_THREE]
                     && !pin_s.sck) begin
            hold_ff <= 1'b1;
        end else if (hold_ff && pin_s.dl[sfp_pkg::LINE_THREE]
                     && !pin_s.sck) begin
            hold_ff <= 1'b0;
        end
    end

    // Edges seen while held are dropped; shift state stays put
    assign act = sel & ~hold_ff;
    assign rise_ok = sck_rise & act;
    assign fall_ok = sck_fall & act;

    // ==========================================================
    // Receive path
    // ==========================================================
    logic [7:0] rx_sh_ff;
    logic [3:0] rx_cnt_ff;
    logic instr_done_ff;
    sfp_pkg::sfp_rx_t rx_ff;
    logic [3:0] rw;
    logic [7:0] nxt_rx_sh;
    logic [3:0] nxt_rx_cnt;

    assign rw = rx_width(mode_i, instr_done_ff);
    assign nxt_rx_sh = shift_by(rx_sh_ff, rw, pin_s.dl);
    assign nxt_rx_cnt = rx_cnt_ff + rw;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rx_sh_ff <= sfp_pkg::BYTE_RST;
            rx_cnt_ff <= sfp_pkg::CNT_RST;
            instr_done_ff <= 1'b0;
        end else if (!sel) begin
            rx_cnt_ff <= sfp_pkg::CNT_RST;
            instr_done_ff <= 1'b0;
        end else if (rise_ok) begin
            rx_sh_ff <= nxt_rx_sh;
            if (nxt_rx_cnt == 4'(sfp_pkg::BYTE_W)) begin
                rx_cnt_ff <= sfp_pkg::CNT_RST;
                instr_done_ff <= 1'b1;
            end else begin
                rx_cnt_ff <= nxt_rx_cnt;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rx_ff <= '0;
        end else begin
            rx_ff.valid <= rise_ok &&
                           nxt_rx_cnt == 4'(sfp_pkg::BYTE_W);
            if (rise_ok && nxt_rx_cnt == 4'(sfp_pkg::BYTE_W)) begin
                rx_ff.data <= nxt_rx_sh;
                rx_ff.instr <= ~instr_done_ff;
            end
        end
    end

    // ==========================================================
    // Transmit path
    // ==========================================================
    logic [7:0] tx_sh_ff;
    logic [3:0] tx_left_ff;
    logic tx_take_ff;
    sfp_pkg::sfp_pin_out_t out_ff;
    logic [3:0] tw;

    assign tw = tx_width(mode_i);

    // Core must present the next byte before the falling edge
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            tx_sh_ff <= sfp_pkg::BYTE_RST;
            tx_left_ff <= sfp_pkg::CNT_RST;
            tx_take_ff <= 1'b0;
            out_ff.dl_out <= 4'h0;
        end else begin
            tx_take_ff <= 1'b0;
            if (!sel) begin
                tx_left_ff <= sfp_pkg::CNT_RST;
            end else if (fall_ok && tx_en_i) begin
                if (tx_left_ff == sfp_pkg::CNT_RST) begin
                    out_ff.dl_out <= top_group(mode_i, tx_byte_i);
                    tx_sh_ff <= shift_by(tx_byte_i, tw, 4'h0);
                    tx_left_ff <= 4'(sfp_pkg::BYTE_W) - tw;
                    tx_take_ff <= 1'b1;
                end else begin
                    out_ff.dl_out <= top_group(mode_i, tx_sh_ff);
                    tx_sh_ff <= shift_by(tx_sh_ff, tw, 4'h0);
                    tx_left_ff <= tx_left_ff - tw;
                end
            end
        end
    end

    // Drive only active lanes; release on deselect or hold
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            out_ff.dl_oe <= 4'h0;
        end else if (act && tx_en_i) begin
            out_ff.dl_oe <= lane_mask(mode_i);
        end else begin
            out_ff.dl_oe <= 4'h0;
        end
    end

    // ==========================================================
    // Protection, power and framing status
    // ==========================================================
    logic hw_prot;
    logic stat_ok_ff;
    logic arr_ok_ff;
    logic standby_ff;
    logic cmd_end_ff;
    logic aligned_ff;

    // Quad enable removes the protect function from line two
    assign hw_prot = ~quad_enable_bit_i &
                     ~pin_s.dl[sfp_pkg::LINE_TWO] &
                     (status_lock_bit_hi_i == sfp_pkg::LOCK_HI_PROT) &
                     (status_lock_bit_lo_i == sfp_pkg::LOCK_LO_PROT);

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            stat_ok_ff <= 1'b1;
            arr_ok_ff <= 1'b1;
        end else begin
            stat_ok_ff <= ~hw_prot;
            arr_ok_ff <= ~(hw_prot & region_hit_i);
        end
    end

    // Hold plays no part here, so internal work runs on
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            standby_ff <= 1'b1;
        end else begin
            standby_ff <= pin_s.cs_n & ~busy_i;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cmd_end_ff <= 1'b0;
            aligned_ff <= 1'b0;
        end else begin
            cmd_end_ff <= cs_rise & armed_ff;
            if (cs_rise && armed_ff) begin
                aligned_ff <= (rx_cnt_ff == sfp_pkg::CNT_RST);
            end
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    logic sel_ff;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sel_ff <= 1'b0;
        end else begin
            sel_ff <= sel;
        end
    end

    assign pins_o = out_ff;
    assign rx_o = rx_ff;
    assign tx_take_o = tx_take_ff;
    assign status_write_allow_o = stat_ok_ff;
    assign array_write_allow_o = arr_ok_ff;
    assign standby_o = standby_ff;
    assign selected_o = sel_ff;
    assign hold_o = hold_ff;
    assign cmd_end_o = cmd_end_ff;
    assign byte_aligned_o = aligned_ff;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sequence s_hold_req;
        sel && hold_func && !hold_ff && !pin_s.dl[3] && !pin_s.sck;
    endsequence

    sequence s_hold_rel;
        sel && hold_func && hold_ff && pin_s.dl[3] && !pin_s.sck;
    endsequence

    rx_on_rise_a: assert property (
        rx_ff.valid |-> $past(sck_rise) && $past(sel) && !$past(hold_ff))
        else $error("byte completed without a rising clock edge");

    out_on_fall_a: assert property (
        $changed(out_ff.dl_out) |-> $past(sck_fall) && $past(tx_en_i))
        else $error("output data changed without a falling edge");

    deselect_release_a: assert property (
        pin_s.cs_n |=> out_ff.dl_oe == 4'h0 && !rx_ff.valid)
        else $error("lines driven while deselected");

    standby_state_a: assert property (
        (pin_s.cs_n && !busy_i) |=> standby_ff ##1 1'b1)
        else $error("standby not entered when idle");

    no_cmd_unarmed_a: assert property (
        !armed_ff |=> !rx_ff.valid && out_ff.dl_oe == 4'h0)
        else $error("activity before first select edge");

    status_lock_a: assert property (
        hw_prot |=> !status_write_allow_o)
        else $error("status write allowed under protection");

    region_lock_a: assert property (
        (hw_prot && region_hit_i) |=> !array_write_allow_o)
        else $error("protected region write allowed");

    quad_unlock_a: assert property (
        quad_enable_bit_i |=> status_write_allow_o)
        else $error("protect pin active with quad enabled");

    hold_enter_a: assert property (
        s_hold_req |=> hold_ff)
        else $error("hold not entered with clock low");

    hold_exit_a: assert property (
        s_hold_rel |=> !hold_ff)
        else $error("hold not left with clock low");

    hold_quiet_a: assert property (
        hold_ff |=> out_ff.dl_oe == 4'h0 && !rx_ff.valid)
        else $error("activity during hold");

    hold_keeps_a: assert property (
        (hold_ff && sel) |=> $stable(rx_cnt_ff) && $stable(tx_left_ff))
        else $error("shift state moved during hold");

    quad_no_hold_a: assert property (
        !hold_func |=> !hold_ff)
        else $error("hold active in quad operation");

    single_lane_a: assert property (
        (act && tx_en_i && mode_i == sfp_pkg::MODE_SINGLE)
        |=> out_ff.dl_oe == sfp_pkg::MASK_SINGLE)
        else $error("single output not on line one only");

endmodule // sfp_pin_if

// *** testbench/sfp_host.sv ***
// Host-side SPI master model for the pin interface bench
`timescale 1ns/10ps
module sfp_host (
    input wire logic clock_i, // System clock
    input wire sfp_pkg::sfp_pin_out_t dev_i, // Device line drive
    output sfp_pkg::sfp_pin_in_t pins_o // Resolved pin levels
);
    logic cs_n, sck, flip;
    logic [3:0] hdl, hoe;
    // Starts selected so the bench can probe arming
    initial begin
        cs_n = 1'b0;
        sck = 1'b0;
        flip = 1'b0;
        hdl = 4'h0;
        hoe = 4'h0;
    end
    always @(posedge clock_i) flip <= ~flip;
    // ====================
    // Wire resolution
    // ====================
    // Floating low lines toggle so a stale value never passes
    always_comb begin
        pins_o.cs_n = cs_n;
        pins_o.sck = sck;
        for (int i = 0; i < 4; i++) begin
            if (dev_i.dl_oe[i]) pins_o.dl[i] = dev_i.dl_out[i];
            else if (hoe[i]) pins_o.dl[i] = hdl[i];
            else pins_o.dl[i] = (i > 1) ? 1'b1 : flip;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic grp(input logic [3:0] d, oe, output logic [3:0] q);
        hdl = d;
        hoe = oe;
        cyc(4);
        sck = 1'b1;
        cyc(4);
        q = pins_o.dl; // Read data sampled before the next fall
        sck = 1'b0;
    endtask
    task automatic pulse();
        logic [3:0] q;
        grp(hdl, hoe, q);
    endtask
    // MSB group first, group LSB on line zero
    task automatic xfer(input logic [7:0] tx, input int w, input bit rd,
                        output logic [7:0] rx);
        logic [3:0] d, q, m;
        m = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
        rx = 8'h00;
        for (int g = 8 - w; g >= 0; g -= w) begin
            d = 4'(tx >> g) & m;
            grp(d, rd ? ((w == 1) ? 4'h1 : 4'h0) : m, q);
            if (w == 1) q = {3'h0, q[1]};
            else q = q & m;
            rx = (rx << w) | {4'h0, q};
        end
    endtask
    task automatic sel();
        cs_n = 1'b0;
        cyc(4);
    endtask
    task automatic desel();
        hoe = 4'h0;
        cs_n = 1'b1;
        cyc(6);
    endtask
    task automatic low(input int i, input bit on);
        hdl[i] = 1'b0;
        hoe[i] = on;
    endtask
endmodule // sfp_host

// *** testbench/sfp_pin_if_tb_top.sv ***
// Self-checking bench for the serial flash pin interface
`timescale 1ns/10ps
module sfp_pin_if_tb_top;
    logic clock_i, reset_i, tx_en, lk_hi, lk_lo, qe, hit, busy;
    logic take, swa, awa, stby, sel, hold, cend, algn, last_ins;
    logic [7:0] tx_byte, got, last_rx;
    sfp_pkg::sfp_mode_t mode;
    sfp_pkg::sfp_pin_in_t pins;
    sfp_pkg::sfp_pin_out_t pout;
    sfp_pkg::sfp_rx_t rx;
    int err_count, comparisons, cycles, nrx, ntake, nend;
    sfp_pin_if uut (.clock_i(clock_i), .reset_i(reset_i), .pins_i(pins),
        .pins_o(pout), .mode_i(mode), .tx_en_i(tx_en),
        .tx_byte_i(tx_byte), .tx_take_o(take), .rx_o(rx),
        .status_lock_bit_hi_i(lk_hi), .status_lock_bit_lo_i(lk_lo),
        .quad_enable_bit_i(qe), .region_hit_i(hit), .busy_i(busy),
        .status_write_allow_o(swa), .array_write_allow_o(awa),
        .standby_o(stby), .selected_o(sel), .hold_o(hold),
        .cmd_end_o(cend), .byte_aligned_o(algn));
    sfp_host host (.clock_i(clock_i), .dev_i(pout), .pins_o(pins));
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (rx.valid === 1'b1) begin
            last_rx <= rx.data;
            last_ins <= rx.instr;
            nrx <= nrx + 1;
        end
        if (take === 1'b1) ntake <= ntake + 1;
        if (cend === 1'b1) nend <= nend + 1;
    end
    // Ceiling well above the thousand or so cycles the run needs
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ====================
    // Scenarios
    // ====================
    task automatic t_unarmed();
        host.xfer(8'h9F, 1, 0, got);
        host.cyc(4);
        chk("unarmed_rx", 8'(nrx), 8'h00);
        chk("unarmed_sel", sel, 1'b0);
        host.desel();
    endtask
    task automatic t_write();
        host.sel();
        host.xfer(8'hA5, 1, 0, got);
        host.cyc(4);
        chk("instr", last_rx, 8'hA5);
        chk("instr_flag", last_ins, 1'b1);
        chk("active", stby, 1'b0);
        host.desel();
        chk("aligned", algn, 1'b1);
        chk("cmd_end", 8'(nend), 8'h01);
        chk("standby", stby, 1'b1);
    endtask
    task automatic t_mode(input sfp_pkg::sfp_mode_t m, input int w,
                          input logic [3:0] oe);
        int t0;
        qe = (w == 4);
        host.sel();
        host.xfer(8'h6B, 1, 0, got);
        mode = m;
        if (m == sfp_pkg::MODE_DUAL_IO || m == sfp_pkg::MODE_QUAD_IO) begin
            host.xfer(8'hC3, w, 0, got);
            host.cyc(4);
            chk("wide_in", last_rx, 8'hC3);
            chk("data_flag", last_ins, 1'b0);
        end
        // Let the last command fall pass before the read phase opens
        host.cyc(4);
        tx_byte = 8'h96 ^ 8'(w);
        t0 = ntake;
        tx_en = 1'b1;
        host.pulse();
        host.xfer(8'hFF, w, 1, got);
        chk("read", got, tx_byte);
        chk("lanes", pout.dl_oe, oe);
        tx_en = 1'b0;
        host.desel();
        chk("release", pout.dl_oe, 4'h0);
        chk("take", 8'(ntake - t0), 8'h01);
    endtask
    // Odd clock count in hold would misalign the byte if not ignored
    task automatic t_hold();
        mode = sfp_pkg::MODE_SINGLE;
        qe = 1'b0;
        host.sel();
        host.xfer(8'h3B, 1, 0, got);
        host.cyc(4);
        tx_byte = 8'hE1;
        tx_en = 1'b1;
        host.pulse();
        host.low(3, 1);
        host.cyc(6);
        chk("hold_in", hold, 1'b1);
        chk("hold_hiz", pout.dl_oe, 4'h0);
        chk("hold_sel", sel, 1'b1);
        repeat (3) host.pulse();
        host.low(3, 0);
        host.cyc(6);
        chk("hold_out", hold, 1'b0);
        host.xfer(8'hFF, 1, 1, got);
        chk("resume", got, 8'hE1);
        tx_en = 1'b0;
        host.desel();
    endtask
    task automatic t_protect();
        host.low(2, 1);
        host.cyc(6);
        chk("sw_block", swa, 1'b0);
        chk("aw_block", awa, 1'b0);
        hit = 1'b0;
        host.cyc(3);
        chk("aw_region", awa, 1'b1);
        chk("sw_still", swa, 1'b0);
        hit = 1'b1;
        lk_hi = 1'b1;
        host.cyc(3);
        chk("sw_hi_unlock", swa, 1'b1);
        lk_hi = 1'b0;
        lk_lo = 1'b0;
        host.cyc(3);
        chk("sw_unlock", swa, 1'b1);
        lk_lo = 1'b1;
        qe = 1'b1;
        host.cyc(3);
        chk("qe_sw", swa, 1'b1);
        chk("qe_aw", awa, 1'b1);
        host.low(2, 0);
        busy = 1'b1;
        host.cyc(3);
        chk("busy_stby", stby, 1'b0);
        busy = 1'b0;
    endtask
    initial begin
        reset_i = 1'b1;
        {tx_en, lk_hi, qe, hit, busy} = 5'h00;
        lk_lo = 1'b1;
        hit = 1'b1;
        tx_byte = 8'h00;
        mode = sfp_pkg::MODE_SINGLE;
        {err_count, comparisons, cycles, nrx} = '0;
        repeat (10) @(negedge clock_i);
        reset_i = 1'b0;
        host.cyc(2);
        chk("rst_stby", stby, 1'b1);
        chk("rst_oe", pout.dl_oe, 4'h0);
        t_unarmed();
        t_write();
        t_mode(sfp_pkg::MODE_SINGLE, 1, 4'h2);
        t_mode(sfp_pkg::MODE_DUAL_OUT, 2, 4'h3);
        t_mode(sfp_pkg::MODE_QUAD_OUT, 4, 4'hF);
        t_mode(sfp_pkg::MODE_DUAL_IO, 2, 4'h3);
        t_mode(sfp_pkg::MODE_QUAD_IO, 4, 4'hF);
        t_hold();
        t_protect();
        test_done();
    end
endmodule // sfp_pin_if_tb_top
